// ===== core/sit_glitch_filter.sv
`include "sit_params.svh"

module sit_glitch_filter import sit_pkg::*; (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Line
	input wire logic raw,
	output logic clean_q
);

	localparam int FILT_CYC = `SIT_FILT_CYC;

	logic [2:0] sync_q;
	logic [3:0] run_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sync_q <= {3{`SIT_LINE_IDLE}};
		end else begin
			sync_q <= {sync_q[1:0], raw};
		end
	end

	// A new level is taken only after it has held longer than the widest spike.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			run_q <= 4'h0;
			clean_q <= `SIT_LINE_IDLE;
		end else if (sync_q[1] != sync_q[2] || sync_q[2] == clean_q) begin
			run_q <= 4'h0;
		end else if (run_q == 4'(FILT_CYC - 1)) begin
			run_q <= 4'h0;
			clean_q <= sync_q[2];
		end else begin
			run_q <= run_q + 4'h1;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	chk_spike_reject: assert property (
		$changed(clean_q) |-> ($past(sync_q[2], 1) == clean_q) && ($past(sync_q[2], FILT_CYC) == clean_q))
		else $error("filtered line changed before the level held long enough");

endmodule

// ===== core/sit_i2c_target.sv
`include "sit_params.svh"

// Notes on behaviour
// - A low level on the interface selector enables the two-wire target.
// - The address strap gives bit 0 of the target address.
// - Target address is 0x20 with strap low, 0x21 with strap high.
// - First byte after start is address then direction bit, one means read.
// - The clock line is never held low by this target.
// - Standard and Fast mode clock rates are accepted.
// - Pulses up to 50 ns on clock or data are ignored.
// - Without core power the target ignores the bus and drives nothing.
// - After start, seven address bits are compared; acknowledge only on match.
// - Writes: pointer byte, then data bytes stored with pointer advance each.
// - Reads advance the pointer after every byte sent.
module sit_i2c_target import sit_pkg::*; (
	// Device clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Register side clock and reset
	input wire logic reg_clk,
	input wire logic reg_rst_b,
	// Bus pins
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Straps and power
	input wire logic if_sel_pin,
	input wire logic cs_b_pin,
	input wire logic addr_lsb_strap,
	input wire logic core_pwr_ok,
	// Register side
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data
);

	// ----------------------------------------------------------------
	// Pin conditioning
	// ----------------------------------------------------------------
	sit_lines_s lines;
	sit_lines_s prev_q;
	sit_straps_s strap_s1_q;
	sit_straps_s strap_s2_q;
	sit_straps_s strap_s3_q;
	sit_straps_s strap_q;
	logic enable;
	logic [6:0] dev_addr;

	sit_glitch_filter u_scl_filt (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.raw(scl_in),
		.clean_q(lines.scl)
	);

	sit_glitch_filter u_sda_filt (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.raw(sda_in),
		.clean_q(lines.sda)
	);

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			prev_q <= {`SIT_LINE_IDLE, `SIT_LINE_IDLE};
		end else begin
			prev_q <= lines;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			strap_s1_q <= `SIT_STRAP_RST;
			strap_s2_q <= `SIT_STRAP_RST;
			strap_s3_q <= `SIT_STRAP_RST;
			strap_q <= `SIT_STRAP_RST;
		end else begin
			strap_s1_q <= {core_pwr_ok, cs_b_pin, if_sel_pin, addr_lsb_strap};
			strap_s2_q <= strap_s1_q;
			strap_s3_q <= strap_s2_q;
			strap_q <= (strap_s2_q & strap_s3_q) | (strap_q & (strap_s2_q ^ strap_s3_q));
		end
	end

	// The chip select check keeps a floating select from enabling the target.
	assign enable = ~strap_q.sel & strap_q.cs_b & strap_q.pwr;
	assign dev_addr = {`SIT_ADDR_HI, strap_q.lsb};

	// ----------------------------------------------------------------
	// Bus events
	// ----------------------------------------------------------------
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic live;
	sit_state_e state_q;
	logic [3:0] cnt_q;
	logic [7:0] shreg_q;
	logic rw_q;
	logic first_q;
	logic [7:0] ptr_q;
	logic [7:0] rd_data_q;
	logic addr_done;
	logic addr_match;
	logic wr_done;
	logic rd_acked;

	assign scl_rise = lines.scl & ~prev_q.scl;
	assign scl_fall = ~lines.scl & prev_q.scl;
	assign start_det = lines.scl & prev_q.scl & prev_q.sda & ~lines.sda;
	assign stop_det = lines.scl & prev_q.scl & ~prev_q.sda & lines.sda;
	assign live = enable & ~start_det & ~stop_det;
	assign addr_done = live && state_q == ST_ADDR && scl_fall && cnt_q == 4'h8;
	assign addr_match = shreg_q[7:1] == dev_addr;
	assign wr_done = live && state_q == ST_WR && scl_fall && cnt_q == 4'h8;
	assign rd_acked = live && state_q == ST_RD_ACK && scl_rise && !lines.sda;

	// ----------------------------------------------------------------
	// Protocol engine
	// ----------------------------------------------------------------
	// Clocking is fully paced by the controller, so the clock pin stays released.
	assign scl_out = 1'b0;
	assign scl_oe = 1'b0;
	assign sda_out = 1'b0;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			shreg_q <= 8'h00;
			rw_q <= 1'b0;
			sda_oe <= 1'b0;
		end else if (!enable || stop_det) begin
			state_q <= ST_IDLE;
			cnt_q <= 4'h0;
			sda_oe <= 1'b0;
		end else if (start_det) begin
			state_q <= ST_ADDR;
			cnt_q <= 4'h0;
			sda_oe <= 1'b0;
		end else begin
			case (state_q)
				ST_ADDR, ST_WR: begin
					if (scl_rise) begin
						shreg_q <= {shreg_q[6:0], lines.sda};
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						if (state_q == ST_WR || addr_match) begin
							sda_oe <= 1'b1;
							state_q <= ST_ACK;
						end else begin
							state_q <= ST_IGNORE;
						end
						if (state_q == ST_ADDR) begin
							rw_q <= shreg_q[0];
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							shreg_q <= rd_data_q;
							sda_oe <= ~rd_data_q[7];
							state_q <= ST_RD;
						end else begin
							sda_oe <= 1'b0;
							state_q <= ST_WR;
						end
					end
				end
				ST_RD: begin
					if (scl_rise) begin
						cnt_q <= cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						sda_oe <= 1'b0;
						state_q <= ST_RD_ACK;
					end else if (scl_fall) begin
						shreg_q <= {shreg_q[6:0], 1'b0};
						sda_oe <= ~shreg_q[6];
					end
				end
				ST_RD_ACK: begin
					// A missing acknowledge ends the read; only start, stop or a lost enable leaves ST_IGNORE.
					if (scl_rise && lines.sda) begin
						state_q <= ST_IGNORE;
					end else if (scl_fall) begin
						cnt_q <= 4'h0;
						shreg_q <= rd_data_q;
						sda_oe <= ~rd_data_q[7];
						state_q <= ST_RD;
					end
				end
				ST_IDLE, ST_IGNORE: begin
					sda_oe <= 1'b0;
				end
				default: begin
					state_q <= ST_IDLE;
					sda_oe <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register pointer and requests to the register side
	// ----------------------------------------------------------------
	sit_xfer_s xfer_q;
	logic wr_tgl_q;
	logic rd_tgl_q;
	logic [2:0] ret_sync_q;
	logic ret_seen_q;
	logic [7:0] ret_data_q;
	logic rd_ret_tgl_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ptr_q <= 8'h00;
			first_q <= 1'b0;
			xfer_q <= '0;
			wr_tgl_q <= 1'b0;
			rd_tgl_q <= 1'b0;
		end else if (addr_done && addr_match) begin
			first_q <= 1'b1;
			if (shreg_q[0]) begin
				xfer_q.addr <= ptr_q;
				rd_tgl_q <= ~rd_tgl_q;
			end
		end else if (wr_done && first_q) begin
			ptr_q <= shreg_q;
			first_q <= 1'b0;
		end else if (wr_done) begin
			xfer_q <= {ptr_q, shreg_q};
			wr_tgl_q <= ~wr_tgl_q;
			ptr_q <= ptr_q + 8'h01;
		end else if (live && state_q == ST_RD_ACK && scl_rise) begin
			ptr_q <= ptr_q + 8'h01;
			if (rd_acked) begin
				xfer_q.addr <= ptr_q + 8'h01;
				rd_tgl_q <= ~rd_tgl_q;
			end
		end
	end

	// Read data is fetched during the acknowledge bit, well before the next low phase needs it.
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ret_sync_q <= 3'h0;
			ret_seen_q <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			ret_sync_q <= {ret_sync_q[1:0], rd_ret_tgl_q};
			ret_seen_q <= ret_sync_q[2];
			if (ret_sync_q[2] != ret_seen_q) begin
				rd_data_q <= ret_data_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register side domain
	// ----------------------------------------------------------------
	logic [2:0] req_s1_q;
	logic [2:0] req_s2_q;
	logic [2:0] req_s3_q;
	logic [1:0] req_seen_q;

	always_ff @(posedge reg_clk) begin
		if (!reg_rst_b) begin
			req_s1_q <= 3'h0;
			req_s2_q <= 3'h0;
			req_s3_q <= 3'h0;
		end else begin
			req_s1_q <= {1'b0, rd_tgl_q, wr_tgl_q};
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
		end
	end

	// The request word is stable for many cycles before its toggle settles here.
	always_ff @(posedge reg_clk) begin
		if (!reg_rst_b) begin
			req_seen_q <= 2'h0;
			reg_wr_en <= 1'b0;
			reg_rd_en <= 1'b0;
			reg_addr <= 8'h00;
			reg_wr_data <= 8'h00;
		end else begin
			req_seen_q <= req_s3_q[1:0];
			reg_wr_en <= req_s3_q[0] ^ req_seen_q[0];
			reg_rd_en <= req_s3_q[1] ^ req_seen_q[1];
			if ((req_s3_q[1:0] ^ req_seen_q) != 2'h0) begin
				reg_addr <= xfer_q.addr;
				reg_wr_data <= xfer_q.data;
			end
		end
	end

	always_ff @(posedge reg_clk) begin
		if (!reg_rst_b) begin
			ret_data_q <= 8'h00;
			rd_ret_tgl_q <= 1'b0;
		end else if (reg_rd_en) begin
			ret_data_q <= reg_rd_data;
			rd_ret_tgl_q <= ~rd_ret_tgl_q;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_active_needs_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q != ST_IDLE |-> !$past(strap_q.sel))
		else $error("engine active while the four-wire port is selected");

	chk_clock_released: assert property (@(posedge sys_clk) disable iff (!rst_b)
		scl_fall |-> !scl_oe ##1 !scl_oe)
		else $error("clock line driven by the target");

	chk_unpowered_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
		!enable |=> !sda_oe && state_q == ST_IDLE)
		else $error("data driven or engine busy without power");

	chk_ack_on_match: assert property (@(posedge sys_clk) disable iff (!rst_b)
		addr_done |=> sda_oe == $past(shreg_q[7:1] == {`SIT_ADDR_HI, strap_q.lsb}))
		else $error("address acknowledge does not follow the compare");

	chk_start_to_addr: assert property (@(posedge sys_clk) disable iff (!rst_b)
		enable && start_det |=> state_q == ST_ADDR && cnt_q == 4'h0 && !sda_oe)
		else $error("start did not restart address reception");

	chk_mismatch_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
		state_q == ST_IGNORE |-> !sda_oe)
		else $error("data driven after a foreign address");

	chk_write_advance: assert property (@(posedge sys_clk) disable iff (!rst_b)
		wr_done && !first_q |=> ptr_q == $past(ptr_q) + 8'h01 && xfer_q.data == $past(shreg_q))
		else $error("write byte not stored or pointer not advanced");

	chk_read_advance: assert property (@(posedge sys_clk) disable iff (!rst_b)
		rd_acked |=> ptr_q == $past(ptr_q) + 8'h01 && rd_tgl_q != $past(rd_tgl_q) && xfer_q.addr == ptr_q)
		else $error("read pointer not advanced or next byte not fetched");

	chk_dir_bit: assert property (@(posedge sys_clk) disable iff (!rst_b)
		addr_done && addr_match |=> rw_q == $past(shreg_q[0]))
		else $error("direction bit not taken from the address byte");

	cov_write_data: cover property (@(posedge sys_clk) disable iff (!rst_b) wr_done && !first_q);
	cov_read_more: cover property (@(posedge sys_clk) disable iff (!rst_b) rd_acked);
	cov_foreign_addr: cover property (@(posedge sys_clk) disable iff (!rst_b) addr_done && !addr_match);
	cov_rep_start: cover property (@(posedge sys_clk) disable iff (!rst_b) start_det && state_q == ST_WR);

endmodule

// ===== core/sit_params.svh
`ifndef SIT_PARAMS_SVH
`define SIT_PARAMS_SVH

// ----------------------------------------------------------------
// Target address
// ----------------------------------------------------------------
// Upper six bits of the 7-bit target address; the strap supplies bit 0.
`define SIT_ADDR_HI 6'h10
`define SIT_ADDR_LO_STRAP0 7'h20
`define SIT_ADDR_LO_STRAP1 7'h21

// ----------------------------------------------------------------
// Bus rates and timing
// ----------------------------------------------------------------
`define SIT_STD_KHZ 100
`define SIT_FAST_KHZ 400
`define SIT_CLK_MHZ 250
`define SIT_SPIKE_NS 50
// Widest spike in whole clock cycles, rounded up.
`define SIT_SPIKE_CYC ((`SIT_SPIKE_NS * `SIT_CLK_MHZ + 999) / 1000)
// A level must hold one cycle longer than the widest spike.
`define SIT_FILT_CYC (`SIT_SPIKE_CYC + 1)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SIT_LINE_IDLE 1'h1
`define SIT_STRAP_RST 4'h6

`endif

// ===== core/sit_pkg.sv
package sit_pkg;

	// ----------------------------------------------------------------
	// Protocol engine states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK,
		ST_WR,
		ST_RD,
		ST_RD_ACK,
		ST_IGNORE
	} sit_state_e;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} sit_xfer_s;

	typedef struct packed {
		logic scl;
		logic sda;
	} sit_lines_s;

	// Order of the strap vector: power good, chip select, selector, address bit.
	typedef struct packed {
		logic pwr;
		logic cs_b;
		logic sel;
		logic lsb;
	} sit_straps_s;

endpackage

// ===== verif/sit_host_model.sv
module sit_host_model import sit_pkg::*; (
	// Clock
	input wire logic sys_clk,
	// Bus lines, one means released
	input wire logic sda_line,
	output logic scl_o,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Bus controller
	// ----------------------------------------------------------------
	// Low phase 1.36 us and high phase 0.68 us meet the Fast mode minimums.
	// The period runs a little faster than 400 kHz to keep the run short.
	localparam int Q = 170;
	// A 48 ns spike sits just under the widest one the target must reject.
	localparam int SPK = 12;

	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic start();
		sda_o = 1'b1;
		tick(Q);
		scl_o = 1'b1;
		tick(Q);
		sda_o = 1'b0;
		tick(Q);
		scl_o = 1'b0;
		tick(Q);
	endtask

	task automatic stop();
		sda_o = 1'b0;
		tick(Q);
		scl_o = 1'b1;
		tick(Q);
		sda_o = 1'b1;
		tick(Q);
	endtask

	task automatic bit_io(input logic b, input logic spk, output logic r);
		sda_o = b;
		tick(Q);
		if (spk) begin
			scl_o = 1'b1;
			tick(SPK);
			scl_o = 1'b0;
			tick(SPK);
		end
		scl_o = 1'b1;
		tick(Q / 2);
		if (spk) begin
			sda_o = ~b;
			tick(SPK);
			sda_o = b;
		end
		r = sda_line;
		tick(Q / 2);
		scl_o = 1'b0;
		tick(Q);
	endtask

	task automatic wr_byte(input logic [7:0] b, input logic spk, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], spk, r);
		end
		bit_io(1'b1, 1'b0, r);
		ack = ~r;
	endtask

	task automatic rd_byte(input logic more, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, 1'b0, r);
			b[i] = r;
		end
		bit_io(~more, 1'b0, r);
	endtask
endmodule

// ===== verif/tb_top.sv
module tb_top import sit_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk, rst_b, reg_clk, reg_rst_b;
	logic if_sel_pin, cs_b_pin, addr_lsb_strap, core_pwr_ok;
	logic scl_o, sda_o, scl_oe, scl_out, sda_oe, sda_out;
	logic reg_wr_en, reg_rd_en, scl_held, a;
	logic [7:0] reg_addr, reg_wr_data, reg_rd_data, d;
	wire logic scl_w = scl_o & ~(scl_oe & ~scl_out);
	wire logic sda_w = sda_o & ~(sda_oe & ~sda_out);
	sit_xfer_s wq[$];
	int err_count, cmp_count;

	// ----------------------------------------------------------------
	// Clocks, register side and monitors
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	initial begin
		reg_clk = 1'b0;
		#13;
		forever #40 reg_clk = ~reg_clk;
	end
	// Reads answer combinationally with a pattern unique to each address.
	assign reg_rd_data = reg_addr ^ 8'h5A;
	always @(posedge reg_clk) begin
		if (reg_wr_en === 1'b1) begin
			wq.push_back({reg_addr, reg_wr_data});
		end
	end
	always @(posedge sys_clk) begin
		if (rst_b !== 1'b1) begin
			scl_held <= 1'b0;
		end else if (scl_oe !== 1'b0) begin
			scl_held <= 1'b1;
		end
	end

	sit_i2c_target dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_clk(reg_clk), .reg_rst_b(reg_rst_b),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .if_sel_pin(if_sel_pin), .cs_b_pin(cs_b_pin), .addr_lsb_strap(addr_lsb_strap),
		.core_pwr_ok(core_pwr_ok), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
	sit_host_model h (.sys_clk(sys_clk), .sda_line(sda_w), .scl_o(scl_o), .sda_o(sda_o));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic end_of_test();
		if (err_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task automatic send(input logic [7:0] b, input logic spk, input logic exp, input string nm);
		h.wr_byte(b, spk, a);
		chk(nm, {15'h0, exp}, {15'h0, a});
	endtask

	task automatic wait_wr(input int n);
		for (int i = 0; i < 500 && wq.size() < n; i++) @(negedge sys_clk);
		chk("reg_wr_count", 16'(n), 16'(wq.size()));
		if (wq.size() < n) end_of_test();
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic sc_write();
		wq.delete();
		h.start();
		send(8'h40, 1'b0, 1'b1, "ack_addr_40");
		send(8'h05, 1'b0, 1'b1, "ack_ptr");
		send(8'hAA, 1'b1, 1'b1, "ack_spiked");
		send(8'h55, 1'b0, 1'b1, "ack_data");
		h.stop();
		wait_wr(2);
		chk("reg_write0", 16'h05AA, wq[0]);
		chk("reg_write1", 16'h0655, wq[1]);
	endtask

	task automatic sc_read();
		wq.delete();
		h.start();
		send(8'h40, 1'b0, 1'b1, "ack_addr_wr");
		send(8'h10, 1'b0, 1'b1, "ack_ptr_rd");
		h.start();
		send(8'h41, 1'b0, 1'b1, "ack_addr_41");
		h.rd_byte(1'b1, d);
		chk("read0", 16'h004A, {8'h00, d});
		h.rd_byte(1'b0, d);
		chk("read1", 16'h004B, {8'h00, d});
		h.stop();
		chk("no_write_rd", 16'h0000, 16'(wq.size()));
	endtask

	task automatic sc_strap();
		wq.delete();
		addr_lsb_strap = 1'b1;
		h.tick(20);
		h.start();
		send(8'h42, 1'b0, 1'b1, "ack_addr_42");
		send(8'h20, 1'b0, 1'b1, "ack_ptr_s1");
		send(8'h33, 1'b0, 1'b1, "ack_data_s1");
		h.start();
		send(8'h40, 1'b0, 1'b0, "nack_addr_40");
		send(8'h77, 1'b0, 1'b0, "nack_ignored");
		h.stop();
		wait_wr(1);
		h.tick(200);
		chk("reg_write_s1", 16'h2033, wq[0]);
		chk("one_write_s1", 16'h0001, 16'(wq.size()));
		addr_lsb_strap = 1'b0;
	endtask

	task automatic sc_off();
		logic [2:0] cfg [3];
		cfg = '{3'b001, 3'b111, 3'b100};
		wq.delete();
		for (int k = 0; k < 3; k++) begin
			{core_pwr_ok, if_sel_pin, cs_b_pin} = cfg[k];
			h.tick(20);
			h.start();
			send(8'h40, 1'b0, 1'b0, "nack_off");
			h.stop();
		end
		{core_pwr_ok, if_sel_pin, cs_b_pin} = 3'b101;
		h.tick(200);
		chk("no_write_off", 16'h0000, 16'(wq.size()));
	endtask

	initial begin
		rst_b = 1'b0;
		reg_rst_b = 1'b0;
		if_sel_pin = 1'b0;
		cs_b_pin = 1'b1;
		addr_lsb_strap = 1'b0;
		core_pwr_ok = 1'b1;
		err_count = 0;
		cmp_count = 0;
		repeat (5) @(negedge sys_clk);
		rst_b = 1'b1;
		// The register side resets only on its own edges, so it is held for five of them.
		repeat (5) @(negedge reg_clk);
		reg_rst_b = 1'b1;
		h.tick(30);
		sc_write();
		sc_read();
		sc_strap();
		sc_off();
		chk("scl_oe_held", 16'h0000, {15'h0, scl_held});
		end_of_test();
	end
endmodule
